// file: switch_fault_regs.vh
// switch_fault_regs.vh: constants for the switch and lin fault control block
// assumes inclusion by the design, its checker and its bench
`ifndef SWITCH_FAULT_REGS_VH
`define SWITCH_FAULT_REGS_VH

// ==========================================================================
// clock and timing
`define REF_CLK_KHZ          20000
`define TXD_STUCK_TIME_MS    1000
`define UV_DEGLITCH_TIME_US  10
`define UV_DEGLITCH_CYCLES   ((`UV_DEGLITCH_TIME_US * `REF_CLK_KHZ) / 1000)
`define TXD_CNT_W            25
`define UV_CNT_W             8

// ==========================================================================
// positions in the synchronised indication vector
`define SYNC_W               15
`define SX_PWM               0
`define SX_HS_OT             1
`define SX_HS_OL             2
`define SX_HS_CL             3
`define SX_LS_OT             4
`define SX_LS1_OL            5
`define SX_LS2_OL            6
`define SX_LS1_CL            7
`define SX_LS2_CL            8
`define SX_HV                9
`define SX_UV                10
`define SX_LIN_OT            11
`define SX_RXD_SHORT         12
`define SX_TXD               13
`define SX_RXD               14

// ==========================================================================
// slew rate encodings and reset values
`define SLEW_20K             2'h0
`define SLEW_10K4            2'h1
`define SLEW_FAST            2'h2
`define SLEW_RESET           `SLEW_20K
`define COMPLIANCE_RESET     1'b0

// ==========================================================================
// interrupt source codes
`define SRC_NONE             4'h0
`define SRC_HIGH_SIDE        4'h2
`define SRC_LOW_SIDE         4'h3
`define SRC_LIN              4'h4

`endif

// file: switch_and_lin_fault_control.v
// switch_and_lin_fault_control.v: gating and protection of the high side,
// two low side switches and the lin transmitter.
// assumes control bits and strobes come from the spi register logic on ref_clk;
// fault indications and lin pins arrive asynchronously and are synchronised here.
//
// Function
// - high side output follows its enable bit
// - enable plus pwm select: high side output follows the pwm pin
// - high side open-load flag set while current is below threshold
// - high side current-limit flag set while in current limitation
// - high side over-temperature shuts output off and latches interrupt source
// - high side thermal shutdown sets open-load and current-limit flags together
// - high side over-temperature drives interrupt only when its mask is set
// - after thermal shutdown, high side control write with condition gone re-enables
// - high voltage with shutdown enabled turns high side off until later write
// - high side stays operable in sleep and stop modes
// - each low side switch follows its enable, or pwm pin when selected
// - separate open-load flag per low side output
// - separate current-limit flag per low side output
// - low side over-temperature turns both off, latches source, masked interrupt
// - low side thermal shutdown holds until low side write with condition gone
// - high voltage with shutdown enabled turns both low sides off until write
// - both low side outputs forced off in sleep or stop mode
// - two-bit slew field selects 10.4k, 20k or fast; resets to 20k
// - compliance on: deglitched undervoltage disables transmitter only when txd recessive
// - lin over-temperature shuts transmitter, sets flag, resumes when gone and txd high
// - rxd short while transmitting sets flag, stops transmitter; rxd edge with txd high re-enables
// - txd low over one second stops transmitter, sets flag; txd high re-enables
// - masked fault keeps interrupt line high and sets no source code
`timescale 1ns/1ns
`include "switch_fault_regs.vh"

module switch_and_lin_fault_control #(
   parameter [`TXD_CNT_W-1:0] TXD_STUCK_CYCLES = `TXD_STUCK_TIME_MS * `REF_CLK_KHZ
) (
   input  wire       ref_clk,
   input  wire       rst_b,
   // register strobes and control bits
   input  wire       hs_ctrl_write,
   input  wire       high_side_enable,
   input  wire       high_side_pwm_select,
   input  wire       ls_ctrl_write,
   input  wire       low_side_one_enable,
   input  wire       low_side_two_enable,
   input  wire       low_side_one_pwm_select,
   input  wire       low_side_two_pwm_select,
   input  wire       lin_ctrl_write,
   input  wire [1:0] slew_rate_select,
   input  wire       undervoltage_compliance_disable,
   input  wire       lin_status_read,
   input  wire       isr_read,
   input  wire       high_voltage_shutdown_enable,
   input  wire       high_side_interrupt_mask,
   input  wire       low_side_interrupt_mask,
   input  wire       lin_interrupt_mask,
   input  wire       low_power_mode,
   // asynchronous indications and pins
   input  wire       pwm_input_pin,
   input  wire       hs_over_temp,
   input  wire       hs_open_load,
   input  wire       hs_current_limit,
   input  wire       ls_over_temp,
   input  wire       ls_one_open_load,
   input  wire       ls_two_open_load,
   input  wire       ls_one_current_limit,
   input  wire       ls_two_current_limit,
   input  wire       high_voltage,
   input  wire       supply_undervoltage,
   input  wire       lin_over_temp,
   input  wire       rxd_short,
   input  wire       txd_pin,
   input  wire       rxd_pin,
   // outputs
   output reg        high_side_drive,
   output reg        low_side_one_drive,
   output reg        low_side_two_drive,
   output reg        lin_tx_enable,
   output reg  [1:0] slew_rate_setting,
   output reg        high_side_open_load_flag,
   output reg        high_side_current_limit_flag,
   output reg        low_side_one_open_load_flag,
   output reg        low_side_two_open_load_flag,
   output reg        low_side_one_current_limit_flag,
   output reg        low_side_two_current_limit_flag,
   output reg        lin_over_temperature_flag,
   output reg        receive_pin_short_flag,
   output reg        transmit_stuck_dominant_flag,
   output reg  [3:0] interrupt_source,
   output reg        irq_b
);

   // =======================================================================
   // input synchronisers
   wire [`SYNC_W-1:0] raw_in;
   reg  [`SYNC_W-1:0] sync_meta;
   reg  [`SYNC_W-1:0] sync_q;
   reg                rxd_prev;

   assign raw_in = {rxd_pin, txd_pin, rxd_short, lin_over_temp, supply_undervoltage,
                    high_voltage, ls_two_current_limit, ls_one_current_limit,
                    ls_two_open_load, ls_one_open_load, ls_over_temp,
                    hs_current_limit, hs_open_load, hs_over_temp, pwm_input_pin};

   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
         // two flops per indication
         always @(posedge ref_clk) begin
            if (!rst_b) begin
               sync_meta[gi] <= 1'b0;
               sync_q[gi]    <= 1'b0;
            end else begin
               sync_meta[gi] <= raw_in[gi];
               sync_q[gi]    <= sync_meta[gi];
            end
         end
      end
   endgenerate

   wire pwm_s   = sync_q[`SX_PWM];
   wire hs_ot_s = sync_q[`SX_HS_OT];
   wire ls_ot_s = sync_q[`SX_LS_OT];
   wire hv_s    = sync_q[`SX_HV];
   wire txd_s   = sync_q[`SX_TXD];
   wire rxd_s   = sync_q[`SX_RXD];

   // =======================================================================
   // control registers loaded by host writes
   reg       hs_en;
   reg       hs_pwm;
   reg [1:0] ls_en;
   reg [1:0] ls_pwm;
   reg       compliance_dis;

   always @(posedge ref_clk) begin
      if (!rst_b) begin
         hs_en             <= 1'b0;
         hs_pwm            <= 1'b0;
         ls_en             <= 2'h0;
         ls_pwm            <= 2'h0;
         slew_rate_setting <= `SLEW_RESET;
         compliance_dis    <= `COMPLIANCE_RESET;
      end else begin
         if (hs_ctrl_write) begin
            hs_en  <= high_side_enable;
            hs_pwm <= high_side_pwm_select;
         end
         if (ls_ctrl_write) begin
            ls_en  <= {low_side_two_enable, low_side_one_enable};
            ls_pwm <= {low_side_two_pwm_select, low_side_one_pwm_select};
         end
         if (lin_ctrl_write) begin
            slew_rate_setting <= slew_rate_select;
            compliance_dis    <= undervoltage_compliance_disable;
         end
      end
   end

   // =======================================================================
   // shutdown latches for the switches
   reg hs_ot_lock;
   reg hs_hv_lock;
   reg ls_ot_lock;
   reg ls_hv_lock;

   wire hs_ot_event = hs_ot_s & ~hs_ot_lock;
   wire ls_ot_event = ls_ot_s & ~ls_ot_lock;

   // set wins; release only by a write after the condition is gone
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         hs_ot_lock <= 1'b0;
         hs_hv_lock <= 1'b0;
         ls_ot_lock <= 1'b0;
         ls_hv_lock <= 1'b0;
      end else begin
         if (hs_ot_s)
            hs_ot_lock <= 1'b1;
         else if (hs_ctrl_write)
            hs_ot_lock <= 1'b0;
         if (hv_s && high_voltage_shutdown_enable)
            hs_hv_lock <= 1'b1;
         else if (hs_ctrl_write && !hv_s)
            hs_hv_lock <= 1'b0;
         if (ls_ot_s)
            ls_ot_lock <= 1'b1;
         else if (ls_ctrl_write)
            ls_ot_lock <= 1'b0;
         if (hv_s && high_voltage_shutdown_enable)
            ls_hv_lock <= 1'b1;
         else if (ls_ctrl_write && !hv_s)
            ls_hv_lock <= 1'b0;
      end
   end

   // =======================================================================
   // driver gating and status flags
   wire       next_hs_drive = hs_en & (~hs_pwm | pwm_s)
                              & ~hs_ot_lock & ~hs_hv_lock;
   wire [1:0] next_ls_drive = ls_en & (~ls_pwm | {2{pwm_s}})
                              & {2{~ls_ot_lock & ~ls_hv_lock & ~low_power_mode}};

   always @(posedge ref_clk) begin
      if (!rst_b) begin
         high_side_drive                 <= 1'b0;
         low_side_one_drive              <= 1'b0;
         low_side_two_drive              <= 1'b0;
         high_side_open_load_flag        <= 1'b0;
         high_side_current_limit_flag    <= 1'b0;
         low_side_one_open_load_flag     <= 1'b0;
         low_side_two_open_load_flag     <= 1'b0;
         low_side_one_current_limit_flag <= 1'b0;
         low_side_two_current_limit_flag <= 1'b0;
      end else begin
         high_side_drive    <= next_hs_drive;
         low_side_one_drive <= next_ls_drive[0];
         low_side_two_drive <= next_ls_drive[1];
         // thermal shutdown shows as all flags of that side set
         high_side_open_load_flag <= sync_q[`SX_HS_OL] | hs_ot_lock;
         high_side_current_limit_flag <= sync_q[`SX_HS_CL] | hs_ot_lock;
         low_side_one_open_load_flag <= sync_q[`SX_LS1_OL] | ls_ot_lock;
         low_side_two_open_load_flag <= sync_q[`SX_LS2_OL] | ls_ot_lock;
         low_side_one_current_limit_flag <= sync_q[`SX_LS1_CL] | ls_ot_lock;
         low_side_two_current_limit_flag <= sync_q[`SX_LS2_CL] | ls_ot_lock;
      end
   end

   // =======================================================================
   // lin supervision counters
   reg [`TXD_CNT_W-1:0] txd_low_cnt;
   reg [`UV_CNT_W-1:0]  uv_cnt;
   reg                  uv_deg;

   wire txd_stuck = (txd_low_cnt >= TXD_STUCK_CYCLES);

   // txd low time and supply undervoltage deglitch
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         txd_low_cnt <= {`TXD_CNT_W{1'b0}};
         uv_cnt      <= {`UV_CNT_W{1'b0}};
         uv_deg      <= 1'b0;
         rxd_prev    <= 1'b0;
      end else begin
         rxd_prev <= rxd_s;
         if (txd_s)
            txd_low_cnt <= {`TXD_CNT_W{1'b0}};
         else if (!txd_stuck)
            txd_low_cnt <= txd_low_cnt + 1'b1;
         if (sync_q[`SX_UV] != uv_deg) begin
            if (uv_cnt >= `UV_DEGLITCH_CYCLES - 1) begin
               uv_deg <= sync_q[`SX_UV];
               uv_cnt <= {`UV_CNT_W{1'b0}};
            end else begin
               uv_cnt <= uv_cnt + 1'b1;
            end
         end else begin
            uv_cnt <= {`UV_CNT_W{1'b0}};
         end
      end
   end

   // =======================================================================
   // lin fault latches and flags
   reg lin_ot_lock;
   reg short_lock;
   reg dom_lock;

   wire rxd_edge    = rxd_s ^ rxd_prev;
   wire short_hit   = sync_q[`SX_RXD_SHORT] & ~txd_s;
   wire lin_event   = (sync_q[`SX_LIN_OT] & ~lin_over_temperature_flag)
                      | (short_hit & ~receive_pin_short_flag)
                      | (txd_stuck & ~transmit_stuck_dominant_flag);
   wire uv_off      = ~compliance_dis & uv_deg & txd_s;
   wire next_tx_en  = ~(lin_ot_lock | short_lock | dom_lock | uv_off);

   always @(posedge ref_clk) begin
      if (!rst_b) begin
         lin_ot_lock                  <= 1'b0;
         short_lock                   <= 1'b0;
         dom_lock                     <= 1'b0;
         lin_over_temperature_flag    <= 1'b0;
         receive_pin_short_flag       <= 1'b0;
         transmit_stuck_dominant_flag <= 1'b0;
         lin_tx_enable                <= 1'b0;
      end else begin
         lin_tx_enable <= next_tx_en;
         if (sync_q[`SX_LIN_OT])
            lin_ot_lock <= 1'b1;
         else if (txd_s)
            lin_ot_lock <= 1'b0;
         if (sync_q[`SX_LIN_OT])
            lin_over_temperature_flag <= 1'b1;
         else if (lin_status_read)
            lin_over_temperature_flag <= 1'b0;
         if (short_hit)
            short_lock <= 1'b1;
         else if (rxd_edge && txd_s)
            short_lock <= 1'b0;
         if (short_hit)
            receive_pin_short_flag <= 1'b1;
         else if (lin_status_read && !sync_q[`SX_RXD_SHORT])
            receive_pin_short_flag <= 1'b0;
         if (txd_stuck)
            dom_lock <= 1'b1;
         else if (txd_s)
            dom_lock <= 1'b0;
         if (txd_stuck)
            transmit_stuck_dominant_flag <= 1'b1;
         else if (lin_status_read && txd_s)
            transmit_stuck_dominant_flag <= 1'b0;
      end
   end

   // =======================================================================
   // interrupt source latch, high side before low side before lin
   reg [3:0] next_source;

   always @* begin
      next_source = `SRC_NONE;
      if (hs_ot_event && high_side_interrupt_mask)
         next_source = `SRC_HIGH_SIDE;
      else if (ls_ot_event && low_side_interrupt_mask)
         next_source = `SRC_LOW_SIDE;
      else if (lin_event && lin_interrupt_mask)
         next_source = `SRC_LIN;
   end

   // new events win over a read clear; masked events leave all as is
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         interrupt_source <= `SRC_NONE;
         irq_b            <= 1'b1;
      end else if (next_source != `SRC_NONE) begin
         interrupt_source <= next_source;
         irq_b            <= 1'b0;
      end else if (isr_read) begin
         interrupt_source <= `SRC_NONE;
         irq_b            <= 1'b1;
      end
   end

endmodule // switch_and_lin_fault_control

// file: switch_fault_props.sv
// switch_fault_props.sv: timing checks on the fault control ports
// assumes one clock ref_clk and a synchronous active low rst_b
`timescale 1ns/1ns
`include "switch_fault_regs.vh"

module switch_fault_props (
   input logic       ref_clk,
   input logic       rst_b,
   input logic       lin_ctrl_write,
   input logic       isr_read,
   input logic       high_side_interrupt_mask,
   input logic       low_side_interrupt_mask,
   input logic       lin_interrupt_mask,
   input logic       low_power_mode,
   input logic       hs_over_temp,
   input logic       ls_over_temp,
   input logic       lin_over_temp,
   input logic       high_side_drive,
   input logic       low_side_one_drive,
   input logic       low_side_two_drive,
   input logic       lin_tx_enable,
   input logic [1:0] slew_rate_setting,
   input logic       high_side_open_load_flag,
   input logic       high_side_current_limit_flag,
   input logic       lin_over_temperature_flag,
   input logic [3:0] interrupt_source,
   input logic       irq_b
);
   // ========================================
   // clocking, idle term and fault sequences
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   wire masked_idle = (interrupt_source == `SRC_NONE) && !high_side_interrupt_mask
                      && !low_side_interrupt_mask && !lin_interrupt_mask;
   sequence no_lin_wr;
      (!lin_ctrl_write) [*3];
   endsequence
   sequence hs_hot;
      (!hs_over_temp && high_side_drive) ##1
      (hs_over_temp && high_side_interrupt_mask && !isr_read) [*6];
   endsequence
   sequence ls_hot;
      (!ls_over_temp && low_side_one_drive) ##1
      (ls_over_temp && low_side_interrupt_mask && !isr_read) [*6];
   endsequence

   // ========================================
   // assertions
   hs_ot_off_a:
      assert property (hs_over_temp [*6] |-> !high_side_drive)
      else $error("high side on while hot");
   hs_ot_flags_a:
      assert property (hs_over_temp [*6] |->
                       high_side_open_load_flag && high_side_current_limit_flag)
      else $error("thermal flags not both set");
   hs_irq_a:
      assert property (hs_hot |-> !irq_b)
      else $error("no request for high side heat");
   ls_ot_off_a:
      assert property (ls_over_temp [*6] |-> !low_side_one_drive && !low_side_two_drive)
      else $error("low side on while hot");
   ls_irq_a:
      assert property (ls_hot |-> !irq_b)
      else $error("no request for low side heat");
   ls_sleep_off_a:
      assert property (low_power_mode |=> !low_side_one_drive && !low_side_two_drive)
      else $error("low side on in low power");
   masked_quiet_a:
      assert property (masked_idle |=> interrupt_source == `SRC_NONE)
      else $error("source set while masked");
   src_irq_a:
      assert property ($rose(interrupt_source != `SRC_NONE) |-> !irq_b)
      else $error("source without request");
   slew_hold_a:
      assert property (no_lin_wr |=> $stable(slew_rate_setting))
      else $error("slew moved without write");
   lin_ot_off_a:
      assert property (lin_over_temp [*6] |-> !lin_tx_enable && lin_over_temperature_flag)
      else $error("transmitter on while hot");
endmodule // switch_fault_props

bind switch_and_lin_fault_control switch_fault_props u_props (.*);

// file: host_model.sv
// host_model.sv: host side writer of control strobes and bits
// assumes the bench calls its tasks; all changes land on falling edges
`timescale 1ns/1ns

module host_model (
   input  logic       ref_clk,
   output logic       hs_ctrl_write,
   output logic       high_side_enable,
   output logic       high_side_pwm_select,
   output logic       ls_ctrl_write,
   output logic       low_side_one_enable,
   output logic       low_side_two_enable,
   output logic       low_side_one_pwm_select,
   output logic       low_side_two_pwm_select,
   output logic       lin_ctrl_write,
   output logic [1:0] slew_rate_select,
   output logic       undervoltage_compliance_disable,
   output logic       lin_status_read,
   output logic       isr_read
);
   // ========================================
   // idle bus and one-cycle strobes
   logic [4:0] stb;
   assign {hs_ctrl_write, ls_ctrl_write, lin_ctrl_write, lin_status_read, isr_read} = stb;
   initial begin
      {stb, high_side_enable, high_side_pwm_select, low_side_one_enable,
       low_side_two_enable, low_side_one_pwm_select, low_side_two_pwm_select,
       slew_rate_select, undervoltage_compliance_disable} = '0;
   end
   task pulse(input logic [4:0] m);
      @(negedge ref_clk);
      stb = m;
      @(negedge ref_clk);
      stb = 5'h00;
   endtask
   // release writes follow the fault, except one high side write that t_hs_fault issues while hs_over_temp is still high
   task hs_wr(input logic en, input logic pw);
      high_side_enable = en;
      high_side_pwm_select = pw;
      pulse(5'h10);
   endtask
   task ls_wr(input logic [3:0] v);
      {low_side_two_pwm_select, low_side_one_pwm_select,
       low_side_two_enable, low_side_one_enable} = v;
      pulse(5'h08);
   endtask
   task lin_wr(input logic [1:0] sr, input logic dis);
      slew_rate_select = sr;
      undervoltage_compliance_disable = dis;
      pulse(5'h04);
   endtask
   task rd_lin;
      pulse(5'h02);
   endtask
   task rd_isr;
      pulse(5'h01);
   endtask
endmodule // host_model

// file: test_switch_and_lin_fault_control.sv
// test_switch_and_lin_fault_control.sv: self-checking bench of the block
// assumes host_model drives the strobes; fault lines are driven here
`timescale 1ns/1ns
`include "switch_fault_regs.vh"

module test_switch_and_lin_fault_control;
   logic       ref_clk, rst_b, hs_ctrl_write, high_side_enable, high_side_pwm_select;
   logic       ls_ctrl_write, low_side_one_enable, low_side_two_enable, lin_ctrl_write;
   logic       low_side_one_pwm_select, low_side_two_pwm_select, lin_status_read;
   logic       undervoltage_compliance_disable, isr_read, high_voltage_shutdown_enable;
   logic       high_side_interrupt_mask, low_side_interrupt_mask, lin_interrupt_mask;
   logic       low_power_mode, pwm_input_pin, hs_over_temp, hs_open_load;
   logic       hs_current_limit, ls_over_temp, ls_one_open_load, ls_two_open_load;
   logic       ls_one_current_limit, ls_two_current_limit, high_voltage, rxd_pin;
   logic       supply_undervoltage, lin_over_temp, rxd_short, txd_pin, irq_b;
   logic       high_side_drive, low_side_one_drive, low_side_two_drive, lin_tx_enable;
   logic       high_side_open_load_flag, high_side_current_limit_flag;
   logic       low_side_one_open_load_flag, low_side_two_open_load_flag;
   logic       low_side_one_current_limit_flag, low_side_two_current_limit_flag;
   logic       lin_over_temperature_flag, receive_pin_short_flag;
   logic       transmit_stuck_dominant_flag;
   logic [1:0] slew_rate_select, slew_rate_setting;
   logic [3:0] interrupt_source;
   int         errors, checks;
   // grouped outputs for compact compares
   wire [3:0]  hsf = {2'h0, high_side_open_load_flag, high_side_current_limit_flag};
   wire [3:0]  lsd = {2'h0, low_side_two_drive, low_side_one_drive};
   wire [3:0]  lsf = {low_side_one_open_load_flag, low_side_two_open_load_flag,
                      low_side_one_current_limit_flag, low_side_two_current_limit_flag};
   wire [3:0]  lnf = {lin_tx_enable, lin_over_temperature_flag, receive_pin_short_flag,
                      transmit_stuck_dominant_flag};

   // short stuck-dominant count keeps the run brief
   switch_and_lin_fault_control #(.TXD_STUCK_CYCLES(25'h0032)) u_dut (.*);
   host_model u_host (.*);

   always #25 ref_clk = ~ref_clk;

   // ========================================
   // compare, wait and closing helpers
   task chk(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_b(input logic got, input logic exp);
      chk({3'h0, got}, {3'h0, exp});
   endtask
   task w(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ========================================
   // scenarios
   task t_reset;
      w(3);
      chk(hsf, 4'h0);
      chk(lsd, 4'h0);
      chk(interrupt_source, `SRC_NONE);
      chk_b(irq_b, 1'b1);
      chk({2'h0, slew_rate_setting}, {2'h0, `SLEW_RESET});
      chk_b(lin_tx_enable, 1'b1);
      $display("reset test done");
   endtask
   task t_hs;
      u_host.hs_wr(1'b1, 1'b0);
      w(2);
      chk_b(high_side_drive, 1'b1);
      u_host.hs_wr(1'b1, 1'b1);
      w(2);
      chk_b(high_side_drive, 1'b0);
      {low_power_mode, pwm_input_pin} = 2'h3;
      w(5);
      chk_b(high_side_drive, 1'b1);
      {pwm_input_pin, hs_open_load} = 2'h1;
      w(5);
      chk(hsf, 4'h2);
      {hs_open_load, hs_current_limit} = 2'h1;
      w(5);
      chk(hsf, 4'h1);
      {hs_current_limit, low_power_mode} = 2'h0;
      u_host.hs_wr(1'b1, 1'b0);
      $display("high side test done");
   endtask
   task t_hs_fault;
      high_side_interrupt_mask = 1'b1;
      w(3);
      hs_over_temp = 1'b1;
      w(6);
      chk_b(high_side_drive, 1'b0);
      chk(hsf, 4'h3);
      chk(interrupt_source, `SRC_HIGH_SIDE);
      chk_b(irq_b, 1'b0);
      u_host.hs_wr(1'b1, 1'b0);
      hs_over_temp = 1'b0;
      w(6);
      chk_b(high_side_drive, 1'b0);
      u_host.rd_isr();
      w(2);
      chk_b(irq_b, 1'b1);
      u_host.hs_wr(1'b1, 1'b0);
      {high_voltage_shutdown_enable, high_voltage} = 2'h3;
      w(6);
      chk_b(high_side_drive, 1'b0);
      high_voltage = 1'b0;
      w(6);
      chk_b(high_side_drive, 1'b0);
      u_host.hs_wr(1'b1, 1'b0);
      w(2);
      chk_b(high_side_drive, 1'b1);
      u_host.hs_wr(1'b0, 1'b0);
      w(2);
      chk_b(high_side_drive, 1'b0);
      {high_voltage_shutdown_enable, high_side_interrupt_mask} = 2'h0;
      $display("high side fault test done");
   endtask
   task t_ls;
      u_host.ls_wr(4'h2);
      w(2);
      chk(lsd, 4'h2);
      u_host.ls_wr(4'hb);
      w(2);
      chk(lsd, 4'h1);
      {pwm_input_pin, ls_one_open_load, ls_two_current_limit} = 3'h7;
      w(5);
      chk(lsd, 4'h3);
      chk(lsf, 4'h9);
      {ls_one_open_load, ls_two_current_limit, ls_two_open_load, ls_one_current_limit} = 4'h3;
      w(5);
      chk(lsf, 4'h6);
      {ls_two_open_load, ls_one_current_limit, pwm_input_pin, ls_over_temp} = 4'h1;
      w(6);
      chk(lsd, 4'h0);
      chk(interrupt_source, `SRC_NONE);
      chk_b(irq_b, 1'b1);
      ls_over_temp = 1'b0;
      w(6);
      chk(lsd, 4'h0);
      u_host.ls_wr(4'h3);
      low_side_interrupt_mask = 1'b1;
      w(2);
      chk(lsd, 4'h3);
      ls_over_temp = 1'b1;
      w(6);
      chk(interrupt_source, `SRC_LOW_SIDE);
      chk_b(irq_b, 1'b0);
      ls_over_temp = 1'b0;
      u_host.rd_isr();
      w(3);
      u_host.ls_wr(4'h3);
      {high_voltage_shutdown_enable, high_voltage} = 2'h3;
      w(6);
      chk(lsd, 4'h0);
      high_voltage = 1'b0;
      w(6);
      chk(lsd, 4'h0);
      u_host.ls_wr(4'h3);
      {high_voltage_shutdown_enable, low_power_mode} = 2'h1;
      w(2);
      chk(lsd, 4'h0);
      low_power_mode = 1'b0;
      w(2);
      chk(lsd, 4'h3);
      $display("low side test done");
   endtask
   task t_lin;
      logic [1:0] sr [3] = '{`SLEW_10K4, `SLEW_FAST, `SLEW_20K};
      for (int i = 0; i < 3; i++) begin
         u_host.lin_wr(sr[i], 1'b0);
         w(2);
         chk({2'h0, slew_rate_setting}, {2'h0, sr[i]});
      end
      {lin_interrupt_mask, lin_over_temp} = 2'h3;
      w(6);
      chk(lnf, 4'h4);
      chk(interrupt_source, `SRC_LIN);
      lin_over_temp = 1'b0;
      w(6);
      chk(lnf, 4'hc);
      u_host.rd_lin();
      u_host.rd_isr();
      {txd_pin, rxd_short} = 2'h1;
      w(6);
      chk(lnf, 4'h2);
      {txd_pin, rxd_short} = 2'h2;
      w(4);
      chk(lnf, 4'h2);
      rxd_pin = 1'b0;
      w(5);
      chk(lnf, 4'ha);
      u_host.rd_lin();
      u_host.rd_isr();
      {rxd_pin, txd_pin} = 2'h2;
      w(60);
      chk(lnf, 4'h1);
      u_host.rd_lin();
      txd_pin = 1'b1;
      w(5);
      chk(lnf, 4'h9);
      u_host.rd_lin();
      u_host.rd_isr();
      supply_undervoltage = 1'b1;
      w(210);
      chk(lnf, 4'h0);
      txd_pin = 1'b0;
      w(4);
      chk(lnf, 4'h8);
      txd_pin = 1'b1;
      u_host.lin_wr(`SLEW_20K, 1'b1);
      w(2);
      chk(lnf, 4'h8);
      $display("lin test done");
   endtask

   // ========================================
   // main sequence and watchdog of about five thousand cycles
   initial begin
      {rst_b, high_voltage_shutdown_enable, high_side_interrupt_mask,
       low_side_interrupt_mask, lin_interrupt_mask, low_power_mode, pwm_input_pin,
       hs_over_temp, hs_open_load, hs_current_limit, ls_over_temp, ls_one_open_load,
       ls_two_open_load, ls_one_current_limit, ls_two_current_limit, high_voltage,
       supply_undervoltage, lin_over_temp, rxd_short, ref_clk} = '0;
      {txd_pin, rxd_pin} = 2'h3;
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_b = 1'b1;
      t_reset;
      t_hs;
      t_hs_fault;
      t_ls;
      t_lin;
      finish_test;
   end
   initial begin
      #(5000 * 50);
      errors++;
      finish_test;
   end
endmodule // test_switch_and_lin_fault_control
